// ===== hw/cbsb_top.sv
// What this block does
// - Size field picks mask or low address bits driven on the lane lines.
// - Interrupt pins read at init as binary divisor; codes 3 to 15 valid.
// - After init interrupt pins are level requests, sampled as levels.
// - Primary system clock is CPU clock divided by the strapped ratio.
// - Delayed system clock copies primary, delayed 0 to 7 CPU cycles.
// - Power-fail pin: offset strap at init, power-fail interrupt later.
// - Machine-check pin: offset strap at init, machine-check request later.
// - Read miss drives 2-bit set number of the set to be filled.
// - Keep-shared input on write-block ack leaves block shared or private.
// - Effective lock flag on fills is system flag AND internal flag.
// - Tag control parity is odd parity over valid, shared, dirty.
// - Tag address parity is odd parity over the 19 tag address bits.
// - Tag write enable low first cycle, then follows write pulse shape bits.
// - Tag RAM output enable asserted during every cache read.
// - Victim-pending asserted while current read miss produced a victim.
// - Cache control bit 26 enables sync RAM clock, aligned to index or sysclk.
// - Top address bit set turns lane lines into low address bits, except size mask and 32-bit writes.
// - Non-cached writes: each lane line marks one 32-bit data quarter valid.
// - Delay offset strapped from halt, power-fail and machine-check pins.
`timescale 1ns/1ps
`default_nettype none
module cbsb_top (
  input  wire logic              REF_CLK,
  input  wire logic              ARST_N,
  input  wire logic              SUPPLY_GOOD_IN,
  // AXI4-Lite slave
  input  wire logic [7:0]        S_AXI_AWADDR,
  input  wire logic              S_AXI_AWVALID,
  output logic                   S_AXI_AWREADY,
  input  wire logic [31:0]       S_AXI_WDATA,
  input  wire logic [3:0]        S_AXI_WSTRB,
  input  wire logic              S_AXI_WVALID,
  output logic                   S_AXI_WREADY,
  output logic [1:0]             S_AXI_BRESP,
  output logic                   S_AXI_BVALID,
  input  wire logic              S_AXI_BREADY,
  input  wire logic [7:0]        S_AXI_ARADDR,
  input  wire logic              S_AXI_ARVALID,
  output logic                   S_AXI_ARREADY,
  output logic [31:0]            S_AXI_RDATA,
  output logic [1:0]             S_AXI_RRESP,
  output logic                   S_AXI_RVALID,
  input  wire logic              S_AXI_RREADY,
  // Straps and interrupt pins
  input  wire logic [3:0]        IRQ_IN,
  input  wire logic              HALT_IRQ_IN,
  input  wire logic              PWR_FAIL_IRQ_IN,
  input  wire logic              MCHK_IRQ_IN,
  // Transfer side band from core
  input  wire cbsb_pkg::cbsb_xfer_s XFER,
  output logic [3:0]             LANE_QUALIFIER_LINES,
  // Read miss / fill
  input  wire logic              READ_MISS,
  input  wire logic [1:0]        MISS_SET,
  input  wire logic              MISS_VICTIM,
  output logic [1:0]             SET_NUMBER,
  output logic                   VICTIM_PENDING,
  input  wire logic              FILL,
  input  wire logic              SYSTEM_LOCK_FLAG_IN,
  output logic                   LOCK_FLAG_EFF,
  input  wire logic              WB_ACK,
  input  wire logic              KEEP_SHARED_IN,
  output logic                   BLOCK_SHARED,
  // Tag interface
  input  wire cbsb_pkg::cbsb_tag_s TAG_IN,
  input  wire logic [18:0]       TAG_WR_ADDR,
  input  wire logic [2:0]        TAG_WR_STATE,
  output cbsb_pkg::cbsb_tag_s    TAG_OUT,
  output logic                   TAG_PAR_ERR,
  input  wire logic              BC_READ,
  input  wire logic              TAG_WRITE,
  input  wire logic              BC_PRIVATE,
  input  wire logic              INDEX_TICK,
  output logic                   TAG_RAM_OE,
  output logic                   TAG_RAM_WE,
  output logic                   SYNC_RAM_CLOCK,
  // Clocks and requests out
  output logic                   PRIMARY_SYSTEM_CLOCK,
  output logic                   PRIMARY_SYSTEM_CLOCK_N,
  output logic                   DELAYED_SYSTEM_CLOCK,
  output logic                   DELAYED_SYSTEM_CLOCK_N,
  output logic [3:0]             IRQ_LEVEL,
  output logic                   PWR_FAIL_REQ,
  output logic                   MCHK_REQ,
  output logic                   HALT_REQ
);

  // Pin synchronisers
  logic [6:0] pin_s1_r;
  logic [6:0] pin_s2_r;
  logic [1:0] sg_s_r;
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pin_s1_r <= 7'h00;
      pin_s2_r <= 7'h00;
      sg_s_r   <= 2'h0;
    end else begin
      pin_s1_r <= {HALT_IRQ_IN, PWR_FAIL_IRQ_IN, MCHK_IRQ_IN, IRQ_IN};
      pin_s2_r <= pin_s1_r;
      sg_s_r   <= {sg_s_r[0], SUPPLY_GOOD_IN};
    end
  end
  wire logic [3:0] irq_s  = pin_s2_r[3:0];
  wire logic       mchk_s = pin_s2_r[4];
  wire logic       pf_s   = pin_s2_r[5];
  wire logic       halt_s = pin_s2_r[6];

  // Init phase: held until supply good seen after reset release
  logic init_r;
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      init_r <= 1'b1;
    end else if (init_r && sg_s_r[1]) begin
      init_r <= 1'b0;
    end
  end

  // Strap capture, frozen after init
  logic [3:0] ratio_r;
  logic [2:0] offset_r;
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ratio_r  <= cbsb_pkg::RATIO_DFL;
      offset_r <= 3'h0;
    end else if (init_r) begin
      ratio_r  <= (irq_s < cbsb_pkg::RATIO_MIN) ? cbsb_pkg::RATIO_DFL : irq_s;
      offset_r <= {halt_s, pf_s, mchk_s};
    end
  end

  // Level interrupt requests after init
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      IRQ_LEVEL    <= 4'h0;
      PWR_FAIL_REQ <= 1'b0;
      MCHK_REQ     <= 1'b0;
      HALT_REQ     <= 1'b0;
    end else begin
      IRQ_LEVEL    <= init_r ? 4'h0 : irq_s;
      PWR_FAIL_REQ <= !init_r && pf_s;
      MCHK_REQ     <= !init_r && mchk_s;
      HALT_REQ     <= !init_r && halt_s;
    end
  end

  // System clock divider; high phase gets the extra cycle when odd
  logic [3:0] div_cnt_r;
  logic       sclk_r;
  logic [6:0] sclk_hist_r;
  wire logic [3:0] high_len = ratio_r - (ratio_r >> 1);
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      div_cnt_r <= 4'h0;
      sclk_r    <= 1'b0;
    end else if (init_r || div_cnt_r == ratio_r - 4'h1) begin
      div_cnt_r <= 4'h0;
      sclk_r    <= !init_r;
    end else begin
      div_cnt_r <= div_cnt_r + 4'h1;
      sclk_r    <= (div_cnt_r + 4'h1) < high_len;
    end
  end
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      sclk_hist_r <= 7'h00;
    end else begin
      sclk_hist_r <= {sclk_hist_r[5:0], sclk_r};
    end
  end
  wire logic [7:0] sclk_taps = {sclk_hist_r, sclk_r};
  assign PRIMARY_SYSTEM_CLOCK   = sclk_r;
  assign PRIMARY_SYSTEM_CLOCK_N = !sclk_r;
  assign DELAYED_SYSTEM_CLOCK   = sclk_taps[offset_r];
  assign DELAYED_SYSTEM_CLOCK_N = !sclk_taps[offset_r];

  // Registers
  logic [31:0] ctrl_r;
  logic [31:0] cache_ctl_r;
  logic [8:0]  we_shape_r;

  // Lane line encoding
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      LANE_QUALIFIER_LINES <= 4'h0;
    end else if (XFER.addr_top) begin
      case (XFER.size)
        cbsb_pkg::SZ_MASK: LANE_QUALIFIER_LINES <= XFER.mask;
        cbsb_pkg::SZ_W32:  LANE_QUALIFIER_LINES <= XFER.is_write ? XFER.mask : {XFER.low_addr[3:2], 2'h0};
        cbsb_pkg::SZ_W16:  LANE_QUALIFIER_LINES <= {XFER.low_addr[3:1], 1'b0};
        default:           LANE_QUALIFIER_LINES <= XFER.low_addr;
      endcase
    end else if (XFER.noncached) begin
      LANE_QUALIFIER_LINES <= XFER.mask;
    end else begin
      LANE_QUALIFIER_LINES <= 4'h0;
    end
  end

  // Miss, victim, lock and shared side band
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      SET_NUMBER     <= 2'h0;
      VICTIM_PENDING <= 1'b0;
      LOCK_FLAG_EFF  <= 1'b0;
      BLOCK_SHARED   <= 1'b0;
    end else begin
      if (READ_MISS) begin
        SET_NUMBER     <= MISS_SET;
        VICTIM_PENDING <= MISS_VICTIM;
      end else if (FILL) begin
        VICTIM_PENDING <= 1'b0;
      end
      if (FILL) begin
        LOCK_FLAG_EFF <= SYSTEM_LOCK_FLAG_IN && ctrl_r[cbsb_pkg::CTRL_LOCK_BIT];
      end
      if (WB_ACK) begin
        BLOCK_SHARED <= KEEP_SHARED_IN;
      end
    end
  end

  // Tag write data with parity and read parity check
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      TAG_OUT     <= '0;
      TAG_PAR_ERR <= 1'b0;
    end else begin
      TAG_OUT.valid    <= TAG_WR_STATE[2];
      TAG_OUT.shared   <= TAG_WR_STATE[1];
      TAG_OUT.dirty    <= TAG_WR_STATE[0];
      TAG_OUT.ctl_par  <= ~^TAG_WR_STATE;
      TAG_OUT.addr     <= TAG_WR_ADDR;
      TAG_OUT.addr_par <= ~^TAG_WR_ADDR;
      TAG_PAR_ERR <= (BC_READ || FILL) &&
                     ((^{TAG_IN.valid, TAG_IN.shared, TAG_IN.dirty, TAG_IN.ctl_par} == 1'b0) ||
                      (^{TAG_IN.addr, TAG_IN.addr_par} == 1'b0));
    end
  end

  // Tag write pulse shaping
  cbsb_pkg::cbsb_tagw_e tw_state_r;
  logic [3:0] tw_cnt_r;
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tw_state_r <= cbsb_pkg::TW_IDLE;
      tw_cnt_r   <= 4'h0;
    end else begin
      case (tw_state_r)
        cbsb_pkg::TW_IDLE: if (TAG_WRITE) begin
          tw_state_r <= cbsb_pkg::TW_FIRST;
        end
        cbsb_pkg::TW_FIRST: begin
          tw_state_r <= cbsb_pkg::TW_PULSE;
          tw_cnt_r   <= 4'h1;
        end
        cbsb_pkg::TW_PULSE: if (tw_cnt_r == 4'(cbsb_pkg::WE_SHAPE_W - 1)) begin
          tw_state_r <= cbsb_pkg::TW_IDLE;
          tw_cnt_r   <= 4'h0;
        end else begin
          tw_cnt_r <= tw_cnt_r + 4'h1;
        end
        default: tw_state_r <= cbsb_pkg::TW_IDLE;
      endcase
    end
  end
  assign TAG_RAM_WE = (tw_state_r == cbsb_pkg::TW_PULSE) && we_shape_r[tw_cnt_r];
  assign TAG_RAM_OE = BC_READ;
  // Sync RAM clock follows index ticks on private access, sysclk otherwise
  assign SYNC_RAM_CLOCK = cache_ctl_r[cbsb_pkg::CC_SYNC_RAM_EN] &&
                          (BC_PRIVATE ? INDEX_TICK : sclk_r);

  // AXI4-Lite slave
  logic        aw_got_r, w_got_r;
  logic [7:0]  aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  assign S_AXI_AWREADY = !aw_got_r && !S_AXI_BVALID;
  assign S_AXI_WREADY  = !w_got_r && !S_AXI_BVALID;
  assign S_AXI_ARREADY = !S_AXI_RVALID;
  wire logic do_wr = aw_got_r && w_got_r;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      aw_got_r     <= 1'b0;
      w_got_r      <= 1'b0;
      aw_addr_r    <= 8'h00;
      w_data_r     <= 32'h0;
      w_strb_r     <= 4'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= cbsb_pkg::RESP_OKAY;
      ctrl_r       <= cbsb_pkg::CTRL_RST;
      cache_ctl_r  <= cbsb_pkg::CACHE_CTL_RST;
      we_shape_r   <= cbsb_pkg::WE_SHAPE_RST;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_got_r  <= 1'b1;
        aw_addr_r <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_got_r  <= 1'b1;
        w_data_r <= S_AXI_WDATA;
        w_strb_r <= S_AXI_WSTRB;
      end
      if (do_wr) begin
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= cbsb_pkg::RESP_OKAY;
        case (aw_addr_r)
          cbsb_pkg::OFF_CTRL:      ctrl_r      <= merge(ctrl_r, w_data_r, w_strb_r);
          cbsb_pkg::OFF_CACHE_CTL: cache_ctl_r <= merge(cache_ctl_r, w_data_r, w_strb_r);
          cbsb_pkg::OFF_WE_SHAPE:  we_shape_r  <= 9'(merge({23'h0, we_shape_r}, w_data_r, w_strb_r));
          cbsb_pkg::OFF_STATUS, cbsb_pkg::OFF_IRQ: ;
          default:                 S_AXI_BRESP <= cbsb_pkg::RESP_SLVERR;
        endcase
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= 32'h0;
      S_AXI_RRESP  <= cbsb_pkg::RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RRESP  <= cbsb_pkg::RESP_OKAY;
      case (S_AXI_ARADDR)
        cbsb_pkg::OFF_CTRL:      S_AXI_RDATA <= ctrl_r;
        cbsb_pkg::OFF_CACHE_CTL: S_AXI_RDATA <= cache_ctl_r;
        cbsb_pkg::OFF_WE_SHAPE:  S_AXI_RDATA <= {23'h0, we_shape_r};
        cbsb_pkg::OFF_STATUS:    S_AXI_RDATA <= {20'h0, init_r, offset_r, ratio_r, VICTIM_PENDING,
                                                 BLOCK_SHARED, LOCK_FLAG_EFF, TAG_PAR_ERR};
        cbsb_pkg::OFF_IRQ:       S_AXI_RDATA <= {25'h0, HALT_REQ, MCHK_REQ, PWR_FAIL_REQ, IRQ_LEVEL};
        default: begin
          S_AXI_RDATA <= 32'h0;
          S_AXI_RRESP <= cbsb_pkg::RESP_SLVERR;
        end
      endcase
    end else if (S_AXI_RVALID && S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

endmodule : cbsb_top
`default_nettype wire

// ===== hw/cbsb_pkg.sv
package cbsb_pkg;

  // AXI4-Lite register offsets (byte addresses)
  localparam logic [7:0] OFF_CTRL      = 8'h00;
  localparam logic [7:0] OFF_CACHE_CTL = 8'h04;
  localparam logic [7:0] OFF_WE_SHAPE  = 8'h08;
  localparam logic [7:0] OFF_STATUS    = 8'h0c;
  localparam logic [7:0] OFF_IRQ       = 8'h10;

  // Control register fields
  localparam int CTRL_LOCK_BIT = 0;

  // Cache control setting fields
  localparam int CC_SYNC_RAM_EN = 26;

  // Reset values
  localparam logic [31:0] CTRL_RST      = 32'h0000_0000;
  localparam logic [31:0] CACHE_CTL_RST = 32'h0000_0000;
  localparam logic [8:0]  WE_SHAPE_RST  = 9'h1fe;

  // Clock strap limits and tag write shape width
  localparam logic [3:0] RATIO_MIN = 4'h3;
  localparam logic [3:0] RATIO_DFL = 4'h3;
  localparam int         WE_SHAPE_W = 9;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Size field codes for byte/word transfers
  localparam logic [1:0] SZ_MASK = 2'h0;
  localparam logic [1:0] SZ_W32  = 2'h1;
  localparam logic [1:0] SZ_W16  = 2'h2;
  localparam logic [1:0] SZ_B8   = 2'h3;

  typedef struct packed {
    logic       is_write;
    logic       noncached;
    logic       addr_top;
    logic [1:0] size;
    logic [3:0] low_addr;
    logic [3:0] mask;
  } cbsb_xfer_s;

  typedef struct packed {
    logic valid;
    logic shared;
    logic dirty;
    logic ctl_par;
    logic [18:0] addr;
    logic addr_par;
  } cbsb_tag_s;

  typedef enum logic [1:0] {
    TW_IDLE,
    TW_FIRST,
    TW_PULSE
  } cbsb_tagw_e;

endpackage : cbsb_pkg

// ===== test/cbsb_sva.sv
`timescale 1ns/1ps
`default_nettype none
module cbsb_sva (
  input wire logic                REF_CLK,
  input wire logic                ARST_N,
  input wire logic                BC_READ,
  input wire logic                TAG_RAM_OE,
  input wire logic                READ_MISS,
  input wire logic [1:0]          MISS_SET,
  input wire logic                MISS_VICTIM,
  input wire logic [1:0]          SET_NUMBER,
  input wire logic                VICTIM_PENDING,
  input wire logic                FILL,
  input wire logic                SYSTEM_LOCK_FLAG_IN,
  input wire logic                LOCK_FLAG_EFF,
  input wire logic                TAG_WRITE,
  input wire logic                TAG_RAM_WE,
  input wire cbsb_pkg::cbsb_tag_s TAG_OUT,
  input wire logic                PRIMARY_SYSTEM_CLOCK,
  input wire logic                DELAYED_SYSTEM_CLOCK
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);
  logic [3:0] tw_r;
  logic [4:0] per_r;
  logic       seen_r;
  // Tracks the nine busy cycles of a tag write
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tw_r <= 4'h0;
    end else if (tw_r != 4'h0) begin
      tw_r <= (tw_r == 4'h9) ? 4'h0 : tw_r + 4'h1;
    end else if (TAG_WRITE) begin
      tw_r <= 4'h1;
    end
  end
  // Cycles since the last rise of the system clock
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      per_r  <= 5'h0;
      seen_r <= 1'b0;
    end else if ($rose(PRIMARY_SYSTEM_CLOCK)) begin
      per_r  <= 5'h1;
      seen_r <= 1'b1;
    end else if (per_r != 5'h1f) begin
      per_r  <= per_r + 5'h1;
    end
  end
  property p_oe; BC_READ |-> TAG_RAM_OE; endproperty
  a_oe: assert property (p_oe) else $error("tag oe low in read");
  property p_set; READ_MISS |=> SET_NUMBER == $past(MISS_SET); endproperty
  a_set: assert property (p_set) else $error("set number wrong");
  property p_vic; READ_MISS && MISS_VICTIM |=> VICTIM_PENDING; endproperty
  a_vic: assert property (p_vic) else $error("victim not flagged");
  property p_lock; FILL && !SYSTEM_LOCK_FLAG_IN |=> !LOCK_FLAG_EFF; endproperty
  a_lock: assert property (p_lock) else $error("lock flag not anded");
  property p_we1; tw_r == 4'h1 |-> !TAG_RAM_WE; endproperty
  a_we1: assert property (p_we1) else $error("tag we high first cycle");
  property p_ctl; TAG_WRITE && tw_r == 4'h0 |=> ^{TAG_OUT.valid, TAG_OUT.shared, TAG_OUT.dirty, TAG_OUT.ctl_par}; endproperty
  a_ctl: assert property (p_ctl) else $error("tag ctl parity even");
  property p_apar; TAG_WRITE && tw_r == 4'h0 |=> ^{TAG_OUT.addr, TAG_OUT.addr_par}; endproperty
  a_apar: assert property (p_apar) else $error("tag addr parity even");
  property p_per; $rose(PRIMARY_SYSTEM_CLOCK) && seen_r |-> per_r >= 5'd3 && per_r <= 5'd15; endproperty
  a_per: assert property (p_per) else $error("sysclk period out of range");
  property p_dly; $rose(PRIMARY_SYSTEM_CLOCK) |-> ##[0:7] $rose(DELAYED_SYSTEM_CLOCK); endproperty
  a_dly: assert property (p_dly) else $error("delayed clock late");
endmodule : cbsb_sva
bind cbsb_top cbsb_sva u_sva (.*);
`default_nettype wire

// ===== test/cbsb_sys_model.sv
`timescale 1ns/1ps
`default_nettype none
module cbsb_sys_model (
  input  wire logic          clk,
  input  wire logic          arst_n,
  input  wire logic          req,
  input  wire logic          rmm,
  input  wire logic          shr,
  input  wire logic          bad,
  input  wire logic [2:0]    wait_c,
  input  wire logic [18:0]   addr,
  output logic               fill,
  output cbsb_pkg::cbsb_tag_s tag
);
  logic [2:0] cnt_r;
  logic       busy_r;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_r  <= 3'h0;
      busy_r <= 1'b0;
      fill   <= 1'b0;
      tag    <= '0;
    end else begin
      fill <= 1'b0;
      if (req) begin
        busy_r <= 1'b1;
        cnt_r  <= wait_c;
      end else if (busy_r && cnt_r != 3'h0) begin
        cnt_r <= cnt_r - 3'h1;
      end else if (busy_r) begin
        busy_r       <= 1'b0;
        fill         <= 1'b1;
        tag.valid    <= 1'b1;
        tag.shared   <= shr;
        tag.dirty    <= rmm & ~shr;
        tag.ctl_par  <= ~(1'b1 ^ shr ^ (rmm & ~shr)) ^ bad;
        tag.addr     <= addr;
        tag.addr_par <= ~(^addr);
      end else begin
        // Released bus shows the inverse, parity kept
        tag <= ~tag;
      end
    end
  end
endmodule : cbsb_sys_model
`default_nettype wire

// ===== test/cbsb_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cbsb_top_tb;
  logic        REF_CLK, ARST_N, SUPPLY_GOOD_IN, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
  logic        S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
  logic [7:0]  S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA, d;
  logic [3:0]  S_AXI_WSTRB, IRQ_IN, LANE_QUALIFIER_LINES, IRQ_LEVEL;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, MISS_SET, SET_NUMBER, r;
  logic        HALT_IRQ_IN, PWR_FAIL_IRQ_IN, MCHK_IRQ_IN, READ_MISS, MISS_VICTIM, VICTIM_PENDING, FILL;
  logic        SYSTEM_LOCK_FLAG_IN, LOCK_FLAG_EFF, WB_ACK, KEEP_SHARED_IN, BLOCK_SHARED, TAG_PAR_ERR;
  logic        BC_READ, TAG_WRITE, BC_PRIVATE, INDEX_TICK, TAG_RAM_OE, TAG_RAM_WE, SYNC_RAM_CLOCK;
  logic        PRIMARY_SYSTEM_CLOCK, PRIMARY_SYSTEM_CLOCK_N, DELAYED_SYSTEM_CLOCK, DELAYED_SYSTEM_CLOCK_N;
  logic        PWR_FAIL_REQ, MCHK_REQ, HALT_REQ, p_req, p_rmm, p_shr, p_bad;
  logic [18:0] TAG_WR_ADDR;
  logic [2:0]  TAG_WR_STATE, p_wait;
  logic [39:0] pv, dv;
  logic [8:0]  we, sh;
  cbsb_pkg::cbsb_xfer_s XFER;
  cbsb_pkg::cbsb_tag_s  TAG_IN, TAG_OUT;
  int          failures, checks, f, hi;
  cbsb_top DUT (.*);
  cbsb_sys_model u_sys (.clk(REF_CLK), .arst_n(ARST_N), .req(p_req), .rmm(p_rmm), .shr(p_shr), .bad(p_bad),
                        .wait_c(p_wait), .addr(TAG_WR_ADDR), .fill(FILL), .tag(TAG_IN));
  initial begin
    REF_CLK = 1'b0;
    forever #20 REF_CLK = ~REF_CLK;
  end
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] wd, output logic [1:0] rs);
    logic sa, sw, sb;
    @(posedge REF_CLK);
    {S_AXI_AWADDR, S_AXI_WDATA} <= {a, wd};
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h7;
    do begin
      @(negedge REF_CLK);
      sa = S_AXI_AWREADY & S_AXI_AWVALID;
      sw = S_AXI_WREADY & S_AXI_WVALID;
      sb = S_AXI_BVALID;
      rs = S_AXI_BRESP;
      @(posedge REF_CLK);
      if (sa) S_AXI_AWVALID <= 1'b0;
      if (sw) S_AXI_WVALID <= 1'b0;
    end while (sb !== 1'b1);
    S_AXI_BREADY <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] rd, output logic [1:0] rs);
    logic sa, sr;
    @(posedge REF_CLK);
    S_AXI_ARADDR <= a;
    {S_AXI_ARVALID, S_AXI_RREADY} <= 2'h3;
    do begin
      @(negedge REF_CLK);
      sa = S_AXI_ARREADY & S_AXI_ARVALID;
      sr = S_AXI_RVALID;
      {rd, rs} = {S_AXI_RDATA, S_AXI_RRESP};
      @(posedge REF_CLK);
      if (sa) S_AXI_ARVALID <= 1'b0;
    end while (sr !== 1'b1);
    S_AXI_RREADY <= 1'b0;
  endtask : axi_rd
  task automatic fill_do(input logic rm, sd, bd, lk, input logic [2:0] w, input logic [2:0] e);
    @(posedge REF_CLK);
    {p_rmm, p_shr, p_bad, SYSTEM_LOCK_FLAG_IN, p_wait, p_req} <= {rm, sd, bd, lk, w, 1'b1};
    @(posedge REF_CLK);
    p_req <= 1'b0;
    do @(negedge REF_CLK); while (FILL !== 1'b1);
    @(negedge REF_CLK);
    chk("fill", {LOCK_FLAG_EFF, VICTIM_PENDING, TAG_PAR_ERR}, e);
  endtask : fill_do
  function automatic logic [3:0] lexp(input cbsb_pkg::cbsb_xfer_s x);
    if (!x.addr_top) return x.noncached ? x.mask : 4'h0;
    case (x.size)
      cbsb_pkg::SZ_MASK: return x.mask;
      cbsb_pkg::SZ_W32:  return x.is_write ? x.mask : {x.low_addr[3:2], 2'h0};
      cbsb_pkg::SZ_W16:  return {x.low_addr[3:1], 1'b0};
      default:           return x.low_addr;
    endcase
  endfunction : lexp
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (20000) @(posedge REF_CLK);
    failures++;
    tally_and_finish();
  end
  initial begin
    {ARST_N, SUPPLY_GOOD_IN, S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = '0;
    {S_AXI_AWADDR, S_AXI_ARADDR, S_AXI_WDATA, XFER, MISS_SET, TAG_WR_STATE, p_wait} = '0;
    {HALT_IRQ_IN, READ_MISS, MISS_VICTIM, SYSTEM_LOCK_FLAG_IN, WB_ACK, KEEP_SHARED_IN, BC_READ} = '0;
    {TAG_WRITE, BC_PRIVATE, INDEX_TICK, p_req, p_rmm, p_shr, p_bad} = '0;
    {S_AXI_WSTRB, IRQ_IN, PWR_FAIL_IRQ_IN, MCHK_IRQ_IN, TAG_WR_ADDR} = {8'hf5, 2'h3, 19'h5a3c1};
    repeat (20) @(posedge REF_CLK);
    ARST_N <= 1'b1;
    axi_rd(cbsb_pkg::OFF_STATUS, d, r);
    chk("init", d[11], 1'b1);
    SUPPLY_GOOD_IN <= 1'b1;
    repeat (6) @(posedge REF_CLK);
    axi_rd(cbsb_pkg::OFF_STATUS, d, r);
    chk("straps", d & 32'hff0, 32'h350);
    axi_rd(cbsb_pkg::OFF_WE_SHAPE, d, r);
    chk("shape_rst", d, {23'h0, cbsb_pkg::WE_SHAPE_RST});
    axi_rd(cbsb_pkg::OFF_CTRL, d, r);
    chk("ctrl_rst", d, cbsb_pkg::CTRL_RST);
    chk("rresp_ok", r, cbsb_pkg::RESP_OKAY);
    axi_wr(8'h14, 32'h1, r);
    chk("unmapped", r, cbsb_pkg::RESP_SLVERR);
    axi_rd(8'h14, d, r);
    chk("rresp_err", r, cbsb_pkg::RESP_SLVERR);
    chk("rdata_err", d, 32'h0);
    axi_wr(cbsb_pkg::OFF_STATUS, 32'hffff_ffff, r);
    chk("ro_write", r, cbsb_pkg::RESP_OKAY);
    {IRQ_IN, HALT_IRQ_IN, PWR_FAIL_IRQ_IN, MCHK_IRQ_IN} <= 7'h4d;
    repeat (5) @(posedge REF_CLK);
    axi_rd(cbsb_pkg::OFF_IRQ, d, r);
    chk("irq_reg", d, 32'h69);
    chk("irq_out", {IRQ_LEVEL, PWR_FAIL_REQ, MCHK_REQ, HALT_REQ}, 7'h4b);
    axi_rd(cbsb_pkg::OFF_STATUS, d, r);
    chk("straps_held", d & 32'hff0, 32'h350);
    $display("test straps done");
    for (int k = 0; k < 40; k++) begin
      @(negedge REF_CLK);
      {pv[k], dv[k]} = {PRIMARY_SYSTEM_CLOCK, DELAYED_SYSTEM_CLOCK};
    end
    f = 1;
    while (!(pv[f] && !pv[f-1]) && f < 30) f++;
    hi = pv[f] + pv[f+1] + pv[f+2] + pv[f+3] + pv[f+4];
    chk("sysclk", {pv[f+5], pv[f+4], hi[3:0]}, 6'h23);
    chk("dlyclk", {dv[f+3], dv[f+2]}, 2'h2);
    chk("clk_n", {PRIMARY_SYSTEM_CLOCK_N, DELAYED_SYSTEM_CLOCK_N}, {!PRIMARY_SYSTEM_CLOCK, !DELAYED_SYSTEM_CLOCK});
    $display("test clocks done");
    for (int i = 0; i < 16; i++) begin
      @(posedge REF_CLK);
      XFER <= '{is_write: i[0], noncached: 1'b1, addr_top: i[3], size: i[2:1], low_addr: 4'hb, mask: 4'h6};
      @(posedge REF_CLK);
      @(negedge REF_CLK);
      chk("lane", LANE_QUALIFIER_LINES, lexp(XFER));
    end
    $display("test lanes done");
    @(posedge REF_CLK);
    {READ_MISS, MISS_SET, MISS_VICTIM} <= 4'hd;
    @(posedge REF_CLK);
    READ_MISS <= 1'b0;
    @(negedge REF_CLK);
    chk("miss", {SET_NUMBER, VICTIM_PENDING}, 3'h5);
    axi_wr(cbsb_pkg::OFF_CTRL, 32'h1, r);
    fill_do(1'b1, 1'b0, 1'b0, 1'b1, 3'h0, 3'h4);
    fill_do(1'b0, 1'b1, 1'b1, 1'b0, 3'h4, 3'h1);
    axi_wr(cbsb_pkg::OFF_CTRL, 32'h0, r);
    fill_do(1'b1, 1'b1, 1'b0, 1'b1, 3'h2, 3'h0);
    for (int k = 0; k < 2; k++) begin
      @(posedge REF_CLK);
      {WB_ACK, KEEP_SHARED_IN} <= {1'b1, k[0]};
      @(posedge REF_CLK);
      WB_ACK <= 1'b0;
      @(negedge REF_CLK);
      chk("keep_shared", BLOCK_SHARED, k[0]);
    end
    $display("test fills done");
    for (int k = 0; k < 2; k++) begin
      sh = k ? 9'h15a : 9'h0a5;
      axi_wr(cbsb_pkg::OFF_WE_SHAPE, {23'h0, sh}, r);
      @(posedge REF_CLK);
      {TAG_WRITE, TAG_WR_STATE, TAG_WR_ADDR} <= {1'b1, k ? 3'h6 : 3'h5, k ? 19'h00017 : 19'h7fe80};
      @(posedge REF_CLK);
      TAG_WRITE <= 1'b0;
      for (int c = 0; c < 9; c++) begin
        @(negedge REF_CLK);
        we[c] = TAG_RAM_WE;
      end
      chk("tag_we", we, {sh[8:1], 1'b0});
      chk("tag_out", TAG_OUT, k ? {4'hd, 19'h00017, 1'b1} : {4'hb, 19'h7fe80, 1'b0});
    end
    $display("test tag write done");
    @(posedge REF_CLK);
    {BC_READ, BC_PRIVATE} <= 2'h3;
    @(negedge REF_CLK);
    chk("tag_oe", TAG_RAM_OE, 1'b1);
    for (int k = 0; k < 3; k++) begin
      axi_wr(cbsb_pkg::OFF_CACHE_CTL, {5'h0, k != 0, 26'h0}, r);
      BC_PRIVATE <= (k != 2);
      hi = 0;
      for (int c = 0; c < 10; c++) begin
        @(posedge REF_CLK);
        INDEX_TICK <= ~INDEX_TICK;
        @(negedge REF_CLK);
        hi += SYNC_RAM_CLOCK;
      end
      chk("sync_clk", hi, (k == 0) ? 0 : (k == 1) ? 5 : 6);
    end
    $display("test sync clock done");
    tally_and_finish();
  end
endmodule : cbsb_top_tb
`default_nettype wire
